/* inc/mfid_defs.svh */
`ifndef MFID_DEFS_SVH
`define MFID_DEFS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define MFID_NUM_TERM      8
`define MFID_CODE_W        8

// ----------------------------------------------------------------
// function codes of the multi-function inputs
// ----------------------------------------------------------------
`define MFID_FN_NONE       8'h00
`define MFID_FN_PULSE_EN   8'h25
`define MFID_FN_NVM_LOCK   8'h26
`define MFID_FN_TRQ_DIR    8'h27
`define MFID_FN_COAST      8'h28
`define MFID_FN_HAND       8'h29
`define MFID_FN_AUTO       8'h2A
`define MFID_FN_REV_HOME   8'h2C

// ----------------------------------------------------------------
// setting values
// ----------------------------------------------------------------
`define MFID_POS_SRC_A     3'h4
`define MFID_POS_SRC_B     3'h5
`define MFID_MODE_TORQUE   3'h2

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define MFID_OFS_CFG       8'h00
`define MFID_OFS_MAP0      8'h04
`define MFID_OFS_MAP1      8'h08
`define MFID_OFS_KEYPAD    8'h0C
`define MFID_OFS_STATUS    8'h10

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define MFID_CFG_SRC_LSB   0
`define MFID_CFG_MODE_LSB  4
`define MFID_CFG_ANA_BIT   8
`define MFID_CFG_HOME_LSB  12
`define MFID_CFG_RST       32'h0000_0000
`define MFID_MAP_RST       8'h00
`define MFID_KP_RST        2'h0

`endif

/* inc/mfid_pkg.sv */
package mfid_pkg;

   // hand/off/auto as shown to the operator
   typedef enum logic [1:0] {
      MFID_HOA_OFF  = 2'b00,
      MFID_HOA_AUTO = 2'b01,
      MFID_HOA_HAND = 2'b10
   } mfid_hoa_type;

   // keypad hand/auto change sequencer
   typedef enum logic [1:0] {
      MFID_KP_IDLE  = 2'b00,
      MFID_KP_STOP  = 2'b01,
      MFID_KP_APPLY = 2'b10
   } mfid_kp_state_type;

   typedef logic [7:0] mfid_code_type;

endpackage

/* inc/mfid_term_if.sv */
`timescale 1ns/10ps

interface mfid_term_if;
   import mfid_pkg::*;
   mfid_code_type code;
   logic          level;
   logic          rise;
   logic          fall;

   modport term (input code, output level, output rise, output fall);
   modport core (output code, input level, input rise, input fall);
endinterface

/* rtl/mfid_term.sv */
`timescale 1ns/10ps

module mfid_term (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic srst,
   input  wire logic ce,
   // terminal pin
   input  wire logic pin,
   // towards the decoder
   mfid_term_if.term bus
);
   import mfid_pkg::*;

   logic sync1_ff;
   logic sync2_ff;
   logic level_ff;

   // two stages before any logic looks at the pin
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sync1_ff <= 1'b0;
         sync2_ff <= 1'b0;
      end else if (ce) begin
         sync1_ff <= pin;
         sync2_ff <= sync1_ff;
      end
   end

   // delayed copy for edge detection
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         level_ff <= 1'b0;
      end else if (ce) begin
         level_ff <= sync2_ff;
      end
   end

   // edges last one enabled cycle
   assign bus.level = level_ff;
   assign bus.rise  = ce & sync2_ff & ~level_ff;
   assign bus.fall  = ce & ~sync2_ff & level_ff;
endmodule

/* rtl/mfid_top.sv */
`timescale 1ns/10ps
`include "mfid_defs.svh"

// Notes on behaviour
// - code 37 with source 4/5 selects encoder pulses
// - code 38 active blocks nonvolatile writes
// - code 39 negates analog torque in torque mode
// - code 40 while running makes motor coast
// - keypad hand/auto change stops drive first
// - two bits decode to off/auto/hand/off
// - code 44 starts reverse homing per settings
// - reverse homing detected on falling edge
module mfid_top (
   // clock, reset, enable
   input  wire logic                      ref_clk,
   input  wire logic                      srst,
   input  wire logic                      ce,
   // apb slave
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [7:0]                paddr,
   input  wire logic [31:0]               pwdata,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   // terminal pins
   input  wire logic [`MFID_NUM_TERM-1:0] multi_function_input,
   // drive side
   input  wire logic                      drive_running,
   input  wire logic                      nvm_wr_req,
   input  wire logic [15:0]               torque_cmd_in,
   output logic                           pulse_cmd_sel,
   output logic                           nvm_wr_en,
   output logic                           nvm_wr_block,
   output logic      [15:0]               torque_cmd_out,
   output logic                           torque_neg,
   output logic                           coast_stop,
   output logic                           stop_cmd,
   output mfid_pkg::mfid_hoa_type         hoa_status,
   output logic                           homing_rev_start,
   output logic      [7:0]                homing_mode_out
);
   import mfid_pkg::*;

   localparam int NT = `MFID_NUM_TERM;

   // ----------------------------------------------------------------
   // terminals
   // ----------------------------------------------------------------
   mfid_code_type     map_ff [NT];
   logic [NT-1:0]     term_lvl;
   logic [NT-1:0]     term_fall;

   mfid_term_if term_bus [NT] ();

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_term
         mfid_term u_term (
            .ref_clk (ref_clk),
            .srst    (srst),
            .ce      (ce),
            .pin     (multi_function_input[gi]),
            .bus     (term_bus[gi])
         );
         assign term_bus[gi].code = map_ff[gi];
         assign term_lvl[gi]      = term_bus[gi].level;
         assign term_fall[gi]     = term_bus[gi].fall;
      end
   endgenerate

   // any terminal carrying function fn shows a set bit in v
   function automatic logic fn_any(input mfid_code_type fn, input logic [NT-1:0] v);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NT; i++) begin
         if (map_ff[i] == fn && v[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   // ----------------------------------------------------------------
   // function levels and falling edges
   // ----------------------------------------------------------------
   logic act_pulse;
   logic act_lock;
   logic act_trq;
   logic act_coast;
   logic act_hand;
   logic act_auto;
   logic fall_hoa;
   logic fall_home;

   // unassigned code 0 never matches a live function
   always_comb begin
      act_pulse = fn_any(`MFID_FN_PULSE_EN, term_lvl);
      act_lock  = fn_any(`MFID_FN_NVM_LOCK, term_lvl);
      act_trq   = fn_any(`MFID_FN_TRQ_DIR, term_lvl);
      act_coast = fn_any(`MFID_FN_COAST, term_lvl);
      act_hand  = fn_any(`MFID_FN_HAND, term_lvl);
      act_auto  = fn_any(`MFID_FN_AUTO, term_lvl);
      fall_hoa  = fn_any(`MFID_FN_HAND, term_fall) | fn_any(`MFID_FN_AUTO, term_fall);
      fall_home = fn_any(`MFID_FN_REV_HOME, term_fall);
   end

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   logic [31:0]       cfg_ff;
   logic [1:0]        kp_req_ff;
   logic [1:0]        kp_sel_ff;
   logic [31:0]       prdata_ff;
   logic [31:0]       nxt_prdata;
   logic [31:0]       status_word;
   logic              addr_ok;
   logic              wr_acc;
   mfid_kp_state_type kp_state_ff;
   mfid_kp_state_type nxt_kp_state;
   logic [2:0]        pos_src;
   logic [2:0]        ctl_mode;
   logic              trq_analog;

   assign pos_src    = cfg_ff[`MFID_CFG_SRC_LSB +: 3];
   assign ctl_mode   = cfg_ff[`MFID_CFG_MODE_LSB +: 3];
   assign trq_analog = cfg_ff[`MFID_CFG_ANA_BIT];

   // address decode; a frozen block holds the bus in access
   always_comb begin
      case (paddr)
         `MFID_OFS_CFG,
         `MFID_OFS_MAP0,
         `MFID_OFS_MAP1,
         `MFID_OFS_KEYPAD,
         `MFID_OFS_STATUS: addr_ok = 1'b1;
         default:          addr_ok = 1'b0;
      endcase
   end

   assign pready  = ce;
   assign pslverr = psel & penable & ~addr_ok;
   assign wr_acc  = ce & psel & penable & pwrite & addr_ok;
   assign prdata  = prdata_ff;

   // status word assembled from live decoder state
   always_comb begin
      status_word        = 32'h0000_0000;
      status_word[1:0]   = hoa_status;
      status_word[2]     = pulse_cmd_sel;
      status_word[3]     = nvm_wr_block;
      status_word[4]     = torque_neg;
      status_word[5]     = coast_stop;
      status_word[6]     = (kp_state_ff != MFID_KP_IDLE);
      status_word[15:8]  = term_lvl;
   end

   // read data caught in the setup cycle, so it is a flop in access
   always_comb begin
      case (paddr)
         `MFID_OFS_CFG:    nxt_prdata = cfg_ff;
         `MFID_OFS_MAP0:   nxt_prdata = {map_ff[3], map_ff[2], map_ff[1], map_ff[0]};
         `MFID_OFS_MAP1:   nxt_prdata = {map_ff[7], map_ff[6], map_ff[5], map_ff[4]};
         `MFID_OFS_KEYPAD: nxt_prdata = {28'h000_0000, kp_sel_ff, kp_req_ff};
         `MFID_OFS_STATUS: nxt_prdata = status_word;
         default:          nxt_prdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prdata_ff <= 32'h0000_0000;
      end else if (ce && psel && !penable) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // configuration register
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfg_ff <= `MFID_CFG_RST;
      end else if (wr_acc && paddr == `MFID_OFS_CFG) begin
         cfg_ff <= pwdata;
      end
   end

   // function code of each terminal, four to a word
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < NT; i++) begin
            map_ff[i] <= `MFID_MAP_RST;
         end
      end else if (wr_acc && paddr == `MFID_OFS_MAP0) begin
         for (int i = 0; i < 4; i++) begin
            map_ff[i] <= pwdata[8*i +: 8];
         end
      end else if (wr_acc && paddr == `MFID_OFS_MAP1) begin
         for (int i = 0; i < 4; i++) begin
            map_ff[i+4] <= pwdata[8*i +: 8];
         end
      end
   end

   // keypad hand/auto request
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         kp_req_ff <= `MFID_KP_RST;
      end else if (wr_acc && paddr == `MFID_OFS_KEYPAD) begin
         kp_req_ff <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // keypad hand/auto sequencer
   // ----------------------------------------------------------------
   // the new selection waits until the drive reports it has stopped
   always_comb begin
      case (kp_state_ff)
         MFID_KP_IDLE: begin
            nxt_kp_state = (kp_req_ff != kp_sel_ff) ? MFID_KP_STOP : MFID_KP_IDLE;
         end
         MFID_KP_STOP: begin
            nxt_kp_state = drive_running ? MFID_KP_STOP : MFID_KP_APPLY;
         end
         MFID_KP_APPLY: begin
            nxt_kp_state = MFID_KP_IDLE;
         end
         default: begin
            nxt_kp_state = MFID_KP_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         kp_state_ff <= MFID_KP_IDLE;
      end else if (ce) begin
         kp_state_ff <= nxt_kp_state;
      end
   end

   // selection taken only after the stop has completed
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         kp_sel_ff <= `MFID_KP_RST;
      end else if (ce && kp_state_ff == MFID_KP_APPLY) begin
         kp_sel_ff <= kp_req_ff;
      end
   end

   // ----------------------------------------------------------------
   // command outputs
   // ----------------------------------------------------------------
   logic [1:0]   hoa_bits;
   mfid_hoa_type nxt_hoa;

   // bit 1 hand, bit 0 auto; terminals and keypad combine
   assign hoa_bits = {act_hand | kp_sel_ff[1], act_auto | kp_sel_ff[0]};

   always_comb begin
      case (hoa_bits)
         2'b01:   nxt_hoa = MFID_HOA_AUTO;
         2'b10:   nxt_hoa = MFID_HOA_HAND;
         default: nxt_hoa = MFID_HOA_OFF;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         hoa_status <= MFID_HOA_OFF;
      end else if (ce) begin
         hoa_status <= nxt_hoa;
      end
   end

   // stop: pulse on a hand/auto terminal release, level while keypad waits
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stop_cmd <= 1'b0;
      end else if (ce) begin
         stop_cmd <= fall_hoa | (nxt_kp_state == MFID_KP_STOP);
      end
   end

   // position command source
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         pulse_cmd_sel <= 1'b0;
      end else if (ce) begin
         pulse_cmd_sel <= act_pulse &
                          (pos_src == `MFID_POS_SRC_A || pos_src == `MFID_POS_SRC_B);
      end
   end

   // nonvolatile write gate; a request during the lock is dropped, not held
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         nvm_wr_block <= 1'b0;
         nvm_wr_en    <= 1'b0;
      end else if (ce) begin
         nvm_wr_block <= act_lock;
         nvm_wr_en    <= nvm_wr_req & ~act_lock;
      end
   end

   // torque sign only in torque mode with an analog reference
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         torque_neg     <= 1'b0;
         torque_cmd_out <= 16'h0000;
      end else if (ce) begin
         torque_neg     <= act_trq & trq_analog & (ctl_mode == `MFID_MODE_TORQUE);
         if (act_trq && trq_analog && ctl_mode == `MFID_MODE_TORQUE) begin
            torque_cmd_out <= 16'(-torque_cmd_in);
         end else begin
            torque_cmd_out <= torque_cmd_in;
         end
      end
   end

   // coast latches while the input stays on, even after running drops
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         coast_stop <= 1'b0;
      end else if (ce) begin
         coast_stop <= act_coast & (drive_running | coast_stop);
      end
   end

   // reverse homing: release of the normally open switch starts it
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         homing_rev_start <= 1'b0;
         homing_mode_out  <= 8'h00;
      end else if (ce) begin
         homing_rev_start <= fall_home;
         homing_mode_out  <= cfg_ff[`MFID_CFG_HOME_LSB +: 8];
      end
   end

endmodule

/* sim/mfid_props.sv */
`timescale 1ns/10ps
`include "mfid_defs.svh"

module mfid_props (
   // clock and reset
   input wire logic                   ref_clk,
   input wire logic                   srst,
   input wire logic                   ce,
   // apb
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic [7:0]             paddr,
   input wire logic                   pready,
   input wire logic                   pslverr,
   // drive side
   input wire logic                   drive_running,
   input wire logic                   nvm_wr_en,
   input wire logic                   nvm_wr_block,
   input wire logic [15:0]            torque_cmd_in,
   input wire logic [15:0]            torque_cmd_out,
   input wire logic                   torque_neg,
   input wire logic                   coast_stop,
   input wire logic                   stop_cmd,
   input wire mfid_pkg::mfid_hoa_type hoa_status,
   input wire logic                   homing_rev_start
);
   import mfid_pkg::*;

   // ------------
   // port checks
   // ------------
   default clocking @(posedge ref_clk); endclocking
   default disable iff (srst);

   // zero wait states, stall only via ce
   a_pready_ce: assert property (pready == ce)
      else $error("pready differs from ce");
   a_err_map: assert property (pslverr == (psel && penable && !(paddr inside {`MFID_OFS_CFG,
      `MFID_OFS_MAP0, `MFID_OFS_MAP1, `MFID_OFS_KEYPAD, `MFID_OFS_STATUS})))
      else $error("error response on wrong address");
   a_hoa_legal: assert property (hoa_status != 2'b11)
      else $error("hand and auto shown together");
   a_home_pulse: assert property (homing_rev_start |=> !homing_rev_start)
      else $error("homing start longer than one cycle");
   a_coast_cause: assert property ($rose(coast_stop) |-> $past(drive_running))
      else $error("coast without running drive");
   // two blocked cycles in a row leave no room for a stale enable
   a_nvm_block: assert property (nvm_wr_block && $past(nvm_wr_block) |-> !nvm_wr_en)
      else $error("write passed while blocked");
   a_trq_sign: assert property ($past(ce) && !$past(srst) |-> torque_cmd_out ==
      (torque_neg ? -$past(torque_cmd_in) : $past(torque_cmd_in)))
      else $error("torque sign wrong");
   // a held stop is a keypad wait; a one-cycle release pulse may move status
   a_hold_stopped: assert property ($past(stop_cmd) && stop_cmd && drive_running
      |=> $stable(hoa_status))
      else $error("status changed before stop");

   c_home: cover property (homing_rev_start);
   c_coast: cover property ($rose(coast_stop));
   c_wait: cover property (stop_cmd && drive_running);
endmodule

/* sim/mfid_sw_model.sv */
`timescale 1ns/10ps

module mfid_sw_model (
   // clock
   input  wire logic       ref_clk,
   // wanted contact states
   input  wire logic [7:0] want,
   // terminal pins
   output logic      [7:0] pins
);
   // contacts settle a clock after the bench asks; never left unknown
   initial pins = 8'h00;
   always @(posedge ref_clk) begin
      pins <= want;
   end
endmodule

/* sim/tb_top.sv */
`timescale 1ns/10ps
`include "mfid_defs.svh"

module tb_top;
   import mfid_pkg::*;
   // ------------
   // signals
   // ------------
   logic         ref_clk, srst, ce, psel, penable, pwrite, rerr;
   logic         pready, pslverr, drive_running, nvm_wr_req, pulse_cmd_sel;
   logic         nvm_wr_en, nvm_wr_block, torque_neg, coast_stop, stop_cmd, homing_rev_start;
   logic [7:0]   paddr, sw, pins, homing_mode_out;
   logic [31:0]  pwdata, prdata, rdat;
   logic [15:0]  torque_cmd_in, torque_cmd_out;
   mfid_hoa_type hoa_status;
   int           bad_count, compares, cyc, stops, homes, s0;

   mfid_sw_model mfid_sw_model_i (.ref_clk, .want(sw), .pins);
   mfid_top mfid_top_i (.ref_clk, .srst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .multi_function_input(pins), .drive_running, .nvm_wr_req,
      .torque_cmd_in, .pulse_cmd_sel, .nvm_wr_en, .nvm_wr_block, .torque_cmd_out,
      .torque_neg, .coast_stop, .stop_cmd, .hoa_status, .homing_rev_start, .homing_mode_out);

   always #20 ref_clk = ~ref_clk;

   // pulse counters and hang guard, off the sampling edge
   always @(negedge ref_clk) begin
      cyc++;
      if (stop_cmd === 1'b1) stops++;
      if (homing_rev_start === 1'b1) homes++;
      if (cyc == 4000) begin
         bad_count++;
         stop_test();
      end
   end

   // ------------
   // tasks
   // ------------
   task automatic w(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // one apb transfer; held until pready seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdat, e);
   endtask

   task automatic stop_test;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ------------
   // sequence
   // ------------
   initial begin
      ref_clk = 0; srst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0;
      pwdata = 0; drive_running = 0; nvm_wr_req = 0; torque_cmd_in = 16'h1234; sw = 0;
      w(4);
      srst <= 1'b0;
      ce <= 1'b0;
      w(1);
      chk(pready, 1'b0);
      ce <= 1'b1;
      for (int i = 0; i < 5; i++) rd(8'(4 * i), 32'h0000_0000);
      apb(1'b0, 8'h14, 32'h0000_0000);
      chk(rerr, 1'b1);
      chk(rdat, 32'h0000_0000);
      // unmapped terminals must drive nothing
      drive_running <= 1'b1;
      sw <= 8'hFF;
      w(7);
      chk({pulse_cmd_sel, nvm_wr_block, torque_neg, coast_stop, hoa_status}, 0);
      rd(`MFID_OFS_STATUS, 32'h0000_FF00);
      sw <= 8'h00;
      drive_running <= 1'b0;
      w(7);
      chk(homes, 0);
      apb(1'b1, `MFID_OFS_CFG, 32'h000A_5124);
      rd(`MFID_OFS_CFG, 32'h000A_5124);
      chk(homing_mode_out, 8'hA5);
      apb(1'b1, `MFID_OFS_MAP0, 32'h2C27_2625);
      apb(1'b1, `MFID_OFS_MAP1, 32'h2A29_2800);
      // tuning setting lives outside the block; operator keeps it at zero
      sw <= 8'h01;
      for (int s = 3; s < 6; s++) begin
         apb(1'b1, `MFID_OFS_CFG, 32'h000A_5120 | s);
         w(6);
         chk(pulse_cmd_sel, s != 3);
      end
      sw <= 8'h02;
      nvm_wr_req <= 1'b1;
      w(7);
      chk({nvm_wr_block, nvm_wr_en}, 2'b10);
      sw <= 8'h00;
      w(7);
      chk({nvm_wr_block, nvm_wr_en}, 2'b01);
      nvm_wr_req <= 1'b0;
      sw <= 8'h04;
      w(7);
      chk({torque_neg, torque_cmd_out}, 17'h1_EDCC);
      apb(1'b1, `MFID_OFS_CFG, 32'h000A_5025);
      w(3);
      chk({torque_neg, torque_cmd_out}, 17'h0_1234);
      // analog reference but speed mode: sign must stay positive
      apb(1'b1, `MFID_OFS_CFG, 32'h000A_5105);
      w(3);
      chk({torque_neg, torque_cmd_out}, 17'h0_1234);
      sw <= 8'h20;
      w(7);
      chk(coast_stop, 1'b0);
      drive_running <= 1'b1;
      w(3);
      chk(coast_stop, 1'b1);
      drive_running <= 1'b0;
      w(3);
      chk(coast_stop, 1'b1);
      sw <= 8'h00;
      w(7);
      chk(coast_stop, 1'b0);
      s0 = stops;
      sw <= 8'h40;
      w(7);
      chk(hoa_status, MFID_HOA_HAND);
      sw <= 8'hC0;
      w(7);
      chk(hoa_status, MFID_HOA_OFF);
      sw <= 8'h80;
      w(7);
      chk({hoa_status, 8'(stops - s0)}, {MFID_HOA_AUTO, 8'h01});
      sw <= 8'h00;
      w(7);
      chk({hoa_status, 8'(stops - s0)}, {MFID_HOA_OFF, 8'h02});
      s0 = homes;
      sw <= 8'h08;
      w(7);
      chk(homes - s0, 0);
      sw <= 8'h00;
      w(7);
      chk(homes - s0, 1);
      drive_running <= 1'b1;
      apb(1'b1, `MFID_OFS_KEYPAD, 32'h0000_0002);
      w(3);
      chk({stop_cmd, hoa_status}, {1'b1, MFID_HOA_OFF});
      drive_running <= 1'b0;
      w(5);
      chk(hoa_status, MFID_HOA_HAND);
      rd(`MFID_OFS_KEYPAD, 32'h0000_000A);
      // auto request with the drive already stopped
      apb(1'b1, `MFID_OFS_KEYPAD, 32'h0000_0001);
      w(5);
      chk(hoa_status, MFID_HOA_AUTO);
      // mid-run reset must clear the applied keypad choice
      srst <= 1'b1;
      w(2);
      srst <= 1'b0;
      chk(hoa_status, MFID_HOA_OFF);
      rd(`MFID_OFS_KEYPAD, 32'h0000_0000);
      stop_test();
   end
endmodule

bind mfid_top mfid_props mfid_props_i (.ref_clk, .srst, .ce, .psel, .penable, .paddr,
   .pready, .pslverr, .drive_running, .nvm_wr_en, .nvm_wr_block, .torque_cmd_in,
   .torque_cmd_out, .torque_neg, .coast_stop, .stop_cmd, .hoa_status, .homing_rev_start);
